// ---- logic/adc_ctrl_pkg.sv ----
// package: register map, field positions, codes and timing for the converter controller
package adc_ctrl_pkg;
    // register addresses on the plain register port
    localparam logic [7:0] addr_result_high = 8'h1e;
    localparam logic [7:0] addr_control     = 8'h1f;
    localparam logic [7:0] addr_irq_flags   = 8'h0c;
    localparam logic [7:0] addr_irq_enables = 8'h8c;
    localparam logic [7:0] addr_result_low  = 8'h9e;
    localparam logic [7:0] addr_analog_sel  = 8'h9f;
    // converter_control field positions
    localparam int bit_justify = 7;
    localparam int bit_refsel  = 6;
    localparam int bit_chan_hi = 3;
    localparam int bit_chan_lo = 2;
    localparam int bit_go      = 1;
    localparam int bit_power   = 0;
    // irq flag/enable position for conversion done
    localparam int bit_done    = 6;
    // analog select fields
    localparam int bit_clk_hi  = 6;
    localparam int bit_clk_lo  = 4;
    // reset values and write masks
    localparam logic [7:0] rst_control  = 8'h00;
    localparam logic [7:0] rst_irq      = 8'h00;
    localparam logic [7:0] rst_analog   = 8'h0f;
    localparam logic [7:0] mask_control = 8'hcf;
    localparam logic [7:0] mask_analog  = 8'h7f;
    localparam logic [7:0] mask_irq     = 8'hc9;
    // conversion timing in bit periods
    localparam logic [3:0] conv_periods  = 4'h0_b;
    localparam logic [3:0] abort_periods = 4'h0_2;
    // rc clock: nominal period 4 us at 100 MHz clock
    localparam int rc_period_ns = 4000;
    localparam int clk_period_ns = 10;
    localparam logic [8:0] rc_half_cycles = 9'(rc_period_ns / clk_period_ns / 2);
    // one instruction cycle of start delay for rc mode (4 device clocks)
    localparam logic [2:0] instr_cycles = 3'h4;
    // register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;
    // converter sequence states, one-hot
    typedef enum logic [4:0] {
        st_idle    = 5'b00001,
        st_delay   = 5'b00010,
        st_convert = 5'b00100,
        st_abort   = 5'b01000,
        st_off     = 5'b10000
    } conv_state_type;
endpackage

// ---- logic/adc_conversion_controller.sv ----
// design: register file and sequencing for a 10-bit successive approximation converter
// Function
// - clock select picks divider or rc clock
// - go bit starts, reads one while busy
// - done clears go, sets flag, irq
// - clearing go aborts, results kept
// - wait two periods after abort, reacquire
// - bit 7 selects right or left justify
// - bit 6 selects external reference
// - bits 3-2 select analog channel
// - bit 0 powers the converter
// - analog select disables digital input path
// - rc mode delays start one instruction
// - sleep rc conversion finishes, wake or off
// - sleep on other clock aborts, power off
// - reset loads register defaults (analog select 0x0f), keeps results
// - high/low byte split per alignment
// - conversion lasts eleven bit periods
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_controller
    import adc_ctrl_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o_unused_i,
    input  wire logic       sleep_i,
    input  wire logic [9:0] sar_value_i,
    output logic [7:0]      reg_rdata_o,
    output logic            conv_irq_o,
    output logic            wake_o,
    output logic [1:0]      channel_select_o,
    output logic            reference_source_select_o,
    output logic            converter_active_o,
    output logic            sample_o,
    output logic [3:0]      digital_input_disable_o
);
    // register port request as one bundle
    reg_req_type    req;             // bundled register request

    // one-hot sequencer state
    conv_state_type state;           // sequencer state

    // software visible registers
    logic [7:0]     control;         // converter_control storage
    logic [7:0]     analog_sel;      // analog_pin_and_clock_select
    logic [7:0]     irq_flags;       // peripheral_irq_flags
    logic [7:0]     irq_enables;     // peripheral_irq_enables

    // no reset: a read after reset
    // still sees the last conversion
    logic [7:0]     result_high;     // result_high_byte, not reset
    logic [7:0]     result_low;      // result_low_byte, not reset

    // device clock divider
    logic [5:0]     div_count;       // divider for device clock modes
    logic [5:0]     div_limit;       // divider terminal count

    // rc clock model and edge detect
    logic [8:0]     rc_count;        // rc half period counter
    logic           rc_clk;          // rc clock level
    logic           rc_prev;         // rc clock last level
    logic           use_rc;          // rc clock selected

    // bit period bookkeeping
    logic           period_tick;     // one bit period elapsed
    logic [3:0]     period_count;    // bit periods in current phase
    logic [2:0]     delay_count;     // instruction delay for rc mode

    // synchroniser stages
    logic [9:0]     sar_s1;          // sync first stage
    logic [9:0]     sar_s2;          // sync second stage
    logic           sleep_s1;        // sync first stage
    logic           sleep_s2;        // sync second stage

    // decoded events
    logic           done_event;      // conversion finished this cycle
    logic           go_write_clear;  // software clears go
    logic           go_write_set;    // software sets go
    logic           sleep_abort;     // sleep on a non-rc clock
    logic           abort_entry;     // go cleared mid conversion

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // two-flop synchronisers for the analog result and sleep level
    // the result word is held long before done,
    // so its bits settle together
    always_ff @(posedge clock_i) begin
        sar_s1   <= sar_value_i;
        sar_s2   <= sar_s1;
        sleep_s1 <= sleep_i;
        sleep_s2 <= sleep_s1;
    end

    // clock source decode; codes ending in 11 all pick the rc clock
    // terminal count is the ratio less one
    // rc codes leave the divider unused
    always_comb begin
        use_rc = (analog_sel[bit_clk_lo +: 2] == 2'b11);
        unique case (analog_sel[bit_clk_hi:bit_clk_lo])
            3'b000:  div_limit = 6'h01;  // /2
            3'b100:  div_limit = 6'h03;  // /4
            3'b001:  div_limit = 6'h07;  // /8
            3'b101:  div_limit = 6'h0f;  // /16
            3'b010:  div_limit = 6'h1f;  // /32
            3'b110:  div_limit = 6'h3f;  // /64
            default: div_limit = 6'h3f;  // rc codes; divider unused
        endcase
    end

    // rc clock model keeps running even in sleep
    // restarts high when idle or on abort, so the
    // first rising edge is a whole period away
    // and a conversion spans eleven full periods
    always_ff @(posedge clock_i) begin
        if (!resetn_i || state == st_idle || state == st_off || abort_entry) begin
            rc_count <= '0;
            rc_clk   <= 1'b1;
            rc_prev  <= 1'b1;  // no false edge
        end else begin
            rc_prev <= rc_clk;
            if (rc_count == rc_half_cycles - 9'h001) begin
                rc_count <= '0;
                rc_clk   <= ~rc_clk;
            end else begin
                rc_count <= rc_count + 9'h001;
            end
        end
    end

    // device clock divider, restarted when idle so periods align to start
    // and on abort, so recovery is two whole periods
    always_ff @(posedge clock_i) begin
        if (!resetn_i || state == st_idle || state == st_off || abort_entry) begin
            div_count <= '0;
        end else if (div_count == div_limit) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 6'h01;
        end
    end

    // one pulse per bit period
    assign period_tick = use_rc ? (rc_clk & ~rc_prev) : (div_count == div_limit);

    // software abort starts the recovery wait
    assign abort_entry = state == st_convert && go_write_clear;

    assign go_write_set   = req.wr && req.addr == addr_control && req.wdata[bit_go]
                            && control[bit_power];
    assign go_write_clear = req.wr && req.addr == addr_control && !req.wdata[bit_go];
    assign sleep_abort    = sleep_s2 && !use_rc;
    assign done_event     = state == st_convert && period_tick
                            && period_count == conv_periods - 4'h1;

    // conversion sequencer
    // idle: acquisition, waits for go
    // delay: rc only, one instruction
    // convert: eleven bit periods
    // abort: two periods, then idle
    // off: asleep, converter stopped
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state        <= st_idle;
            period_count <= '0;
            delay_count  <= '0;
        end else begin
            unique case (state)
                st_idle: begin
                    period_count <= '0;
                    delay_count  <= '0;
                    if (go_write_set) begin
                        state <= use_rc ? st_delay : st_convert;
                    end
                end

                // rc start delay
                st_delay: begin
                    // lets a sleep instruction retire before sampling ends and the conversion starts
                    delay_count <= delay_count + 3'h1;
                    if (go_write_clear) begin
                        state <= st_abort;
                    end else if (delay_count == instr_cycles - 3'h1) begin
                        state <= st_convert;
                    end
                end

                // sleep beats a software abort
                st_convert: begin
                    if (period_tick) begin
                        period_count <= period_count + 4'h1;
                    end
                    if (sleep_abort) begin
                        state <= st_off;
                    end else if (go_write_clear) begin
                        state        <= st_abort;
                        period_count <= '0;
                    end else if (done_event) begin
                        state <= (sleep_s2 && !irq_enables[bit_done]) ? st_off : st_idle;
                    end
                end

                // recovery after abort
                st_abort: begin
                    if (period_tick) begin
                        period_count <= period_count + 4'h1;
                    end
                    if (period_tick && period_count == abort_periods - 4'h1) begin
                        state <= st_idle;
                    end
                end

                // stopped while asleep
                st_off: begin
                    // module stays off until sleep ends; power bit untouched
                    if (!sleep_s2) begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // control register; go set by software, cleared by hardware
    // clearing go by write also aborts
    // a write wins over the hardware clear
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            control <= rst_control;
        end else if (req.wr && req.addr == addr_control) begin
            control <= req.wdata & mask_control;
            control[bit_go] <= go_write_set;
        end else if (done_event || sleep_abort && state == st_convert) begin
            control[bit_go] <= 1'b0;
        end
    end

    // analog select and clock select register
    // bit 7 unimplemented, reads zero
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            analog_sel <= rst_analog;
        end else if (req.wr && req.addr == addr_analog_sel) begin
            analog_sel <= req.wdata & mask_analog;
        end
    end

    // interrupt enables
    // only implemented bits are kept
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_enables <= rst_irq;
        end else if (req.wr && req.addr == addr_irq_enables) begin
            irq_enables <= req.wdata & mask_irq;
        end
    end

    // interrupt flags; hardware set wins over a software clear
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            irq_flags <= rst_irq;
        end else begin
            if (req.wr && req.addr == addr_irq_flags) begin
                irq_flags <= req.wdata & mask_irq;
            end
            if (done_event) begin
                irq_flags[bit_done] <= 1'b1;
            end
        end
    end

    // results loaded together at completion only; reset leaves them alone
    // an abort never reaches done, so the
    // last completed value stays
    always_ff @(posedge clock_i) begin
        if (done_event) begin
            if (control[bit_justify]) begin
                result_high <= {6'h00, sar_s2[9:8]};
                result_low  <= sar_s2[7:0];
            end else begin
                result_high <= sar_s2[9:2];
                result_low  <= {sar_s2[1:0], 6'h00};
            end
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    // zero otherwise, so it can be or-ed
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= '0;
        end else if (req.rd) begin
            unique case (req.addr)
                addr_result_high: reg_rdata_o <= result_high;
                addr_control:     reg_rdata_o <= control;
                addr_irq_flags:   reg_rdata_o <= irq_flags;
                addr_irq_enables: reg_rdata_o <= irq_enables;
                addr_result_low:  reg_rdata_o <= result_low;
                addr_analog_sel:  reg_rdata_o <= analog_sel;
                default:          reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // registered outputs toward the analog front end and the core
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            conv_irq_o                <= 1'b0;
            wake_o                    <= 1'b0;
            channel_select_o          <= '0;
            reference_source_select_o <= 1'b0;
            converter_active_o        <= 1'b0;
            sample_o                  <= 1'b0;
            digital_input_disable_o   <= rst_analog[3:0];
        end else begin
            conv_irq_o <= irq_flags[bit_done] & irq_enables[bit_done];
            wake_o     <= sleep_s2 & irq_flags[bit_done] & irq_enables[bit_done];
            channel_select_o          <= control[bit_chan_hi:bit_chan_lo];
            reference_source_select_o <= control[bit_refsel];
            // power bit gates operation; off state overrides while asleep
            converter_active_o <= control[bit_power] && state != st_off;
            // acquisition runs when powered and idle or in the rc start delay
            sample_o <= control[bit_power] && (state == st_idle || state == st_delay);
            digital_input_disable_o <= analog_sel[3:0];
        end
    end

    // limitations for the integrator:
    //
    // the rc clock is a counter model
    // with a constant period
    //
    // fast divider codes are accepted;
    // software keeps the bit period legal
    //
    // the result word must stay stable
    // from end of sampling until done
    //
    // go with power off is ignored, so
    // power up in an earlier write
    //
    // sleep in the rc start delay does
    // not abort; the delay exists for it
    //
    // after a sleep abort the sequencer
    // waits in off until wake
    //
    // irq and wake are plain levels;
    // software clears the done flag
    //
    // flag and enable bits outside mask_irq
    // read zero
    //
    // reset keeps both result bytes
endmodule
`default_nettype wire

// ---- verif/adc_ctrl_monitor.sv ----
// checker: port-level timing properties of the converter controller
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor
    import adc_ctrl_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic       sleep_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       conv_irq_o,
    input wire logic       wake_o,
    input wire logic [1:0] channel_select_o,
    input wire logic       reference_source_select_o,
    input wire logic       converter_active_o,
    input wire logic [3:0] digital_input_disable_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // lone control write: one idle write cycle behind it
    sequence s_ctrl_wr;
        reg_wr_i && reg_addr_i == addr_control ##1 !reg_wr_i;
    endsequence
    // lone analog select write
    sequence s_ana_wr;
        reg_wr_i && reg_addr_i == addr_analog_sel ##1 !reg_wr_i;
    endsequence
    // outputs lag the register by one cycle, so two behind the strobe
    chk_chan_copy: assert property (
        s_ctrl_wr |=> channel_select_o == $past(reg_wdata_i[3:2], 2))
        else $error("channel select does not follow control");
    chk_ref_copy: assert property (
        s_ctrl_wr |=> reference_source_select_o == $past(reg_wdata_i[bit_refsel], 2))
        else $error("reference select does not follow control");
    chk_pin_copy: assert property (
        s_ana_wr |=> digital_input_disable_o == $past(reg_wdata_i[3:0], 2))
        else $error("digital input disable does not follow analog select");
    // read data only in the cycle after a read strobe
    chk_rdata_quiet: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    chk_ctrl_readback: assert property (
        (reg_wr_i && reg_addr_i == addr_control && !reg_wdata_i[bit_go]) ##1
        (reg_rd_i && reg_addr_i == addr_control)
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & mask_control))
        else $error("control readback mismatch");
    chk_power_off: assert property (
        (reg_wr_i && reg_addr_i == addr_control && !reg_wdata_i[bit_power]) ##1 !reg_wr_i
        |=> !converter_active_o)
        else $error("converter active with power bit clear");
    chk_irq_masked: assert property (
        (reg_wr_i && reg_addr_i == addr_irq_enables && !reg_wdata_i[bit_done]) ##1 !reg_wr_i
        |=> !conv_irq_o)
        else $error("interrupt with done enable clear");
    // wake needs the core asleep, sync and register included
    chk_wake_awake: assert property (
        !sleep_i [*4] |-> !wake_o)
        else $error("wake while awake");
endmodule
bind adc_conversion_controller adc_ctrl_monitor adc_ctrl_monitor_i (
    .clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .sleep_i,
    .reg_rdata_o, .conv_irq_o, .wake_o, .channel_select_o, .reference_source_select_o,
    .converter_active_o, .digital_input_disable_o
);
`default_nettype wire

// ---- verif/analog_front_end_model.sv ----
// partner: behavioural analog multiplexer and hold capacitor
`timescale 1ns/1ps
`default_nettype none
module analog_front_end_model (
    input  wire logic       clock_i,
    input  wire logic [1:0] channel_select_i,
    input  wire logic       reference_source_select_i,
    input  wire logic       sample_i,
    output logic      [9:0] sar_value_o
);
    // hold capacitor tracks the routed input only while sampling, then holds
    always_ff @(posedge clock_i) begin
        if (sample_i) begin
            sar_value_o <= {reference_source_select_i, channel_select_i, 7'h53};
        end
    end
endmodule
`default_nettype wire

// ---- verif/adc_conversion_controller_test.sv ----
// testbench: registers, conversions per clock code, abort, sleep and reset
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_controller_test import adc_ctrl_pkg::*;;
    logic        clock_i;
    logic        resetn_i;
    logic        sleep_i;
    reg_req_type req;                         // register port request
    logic [7:0]  reg_rdata_o;
    logic        conv_irq_o;
    logic        wake_o;
    logic [1:0]  channel_select_o;
    logic        reference_source_select_o;
    logic        converter_active_o;
    logic        sample_o;
    logic [3:0]  digital_input_disable_o;
    logic [9:0]  sar_value_i;                 // from the front end model
    int          num_errors;
    int          cmp_count;
    logic [2:0]  codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    logic [7:0]  reg_adr [5] = '{addr_control, addr_analog_sel, addr_irq_flags,
                                 addr_irq_enables, 8'h55};
    logic [7:0]  reg_rst [5] = '{rst_control, rst_analog, rst_irq, rst_irq, 8'h00};

    adc_conversion_controller adc_conversion_controller_i (
        .clock_i, .resetn_i, .reg_addr_i(req.addr), .reg_wdata_i(req.wdata),
        .reg_wr_i(req.wr), .reg_rd_i(req.rd), .reg_rdata_o_unused_i(8'h00), .sleep_i,
        .sar_value_i, .reg_rdata_o, .conv_irq_o, .wake_o, .channel_select_o,
        .reference_source_select_o, .converter_active_o, .sample_o, .digital_input_disable_o
    );
    analog_front_end_model analog_front_end_model_i (
        .clock_i, .channel_select_i(channel_select_o),
        .reference_source_select_i(reference_source_select_o), .sample_i(sample_o),
        .sar_value_o(sar_value_i)
    );
    // 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        req <= '0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        req <= '0;
        @(posedge clock_i);
        q = reg_rdata_o;
    endtask
    // write then read with no gap
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        req <= '0;
        @(posedge clock_i);
        q = reg_rdata_o;
    endtask
    task automatic t_regs();
        logic [7:0] q;
        wr(8'h55, 8'hff);
        wr(addr_irq_enables, 8'h00);
        chk("pin disable reset", 16'(digital_input_disable_o), 16'h000f);
        for (int i = 0; i < 5; i++) begin
            rd(reg_adr[i], q);
            chk("reset value", 16'(q), 16'(reg_rst[i]));
        end
        wrrd(addr_analog_sel, 8'hff, q);
        chk("analog select", 16'(q), 16'h007f);
        wrrd(addr_irq_flags, 8'hff, q);
        chk("irq flags", 16'(q), 16'(mask_irq));
        wr(addr_irq_flags, 8'h00);
        wrrd(addr_control, 8'hf4, q);
        chk("control", 16'(q), 16'h00c4);
        wrrd(addr_control, 8'hf6, q);
        chk("go without power", 16'(q), 16'h00c4);
        chk("channel", 16'(channel_select_o), 16'h0001);
        chk("reference", 16'(reference_source_select_o), 16'h0001);
        chk("active", 16'(converter_active_o), 16'h0000);
        $display("register test done");
    endtask
    // one conversion; p is cycles per bit period
    task automatic t_convert(input logic [2:0] code, input int p, input int slack,
                             input logic [7:0] ctl);
        logic [7:0] q;
        logic [9:0] v;
        int         n;
        v = {ctl[6], ctl[3:2], 7'h53};
        wr(addr_analog_sel, {1'b0, code, 4'h5});
        wr(addr_control, ctl);
        repeat (20) @(posedge clock_i);
        chk("pin disable", 16'(digital_input_disable_o), 16'h0005);
        wr(addr_control, ctl | 8'h02);
        rd(addr_control, q);
        chk("go busy", 16'(q[1]), 16'h0001);
        n = 0;
        while (conv_irq_o !== 1'b1 && n < 6000) begin
            @(posedge clock_i);
            n++;
        end
        chk("conversion length", 16'(n >= 11 * p - 4 && n <= 11 * p + slack), 16'h0001);
        if (n == 6000) end_sim();
        rd(addr_control, q);
        chk("go cleared", 16'(q), 16'(ctl & mask_control));
        rd(addr_irq_flags, q);
        chk("done flag", 16'(q), 16'h0040);
        rd(addr_result_high, q);
        chk("result high", 16'(q), ctl[7] ? 16'(v[9:8]) : 16'(v[9:2]));
        rd(addr_result_low, q);
        chk("result low", 16'(q), ctl[7] ? 16'(v[7:0]) : 16'({v[1:0], 6'h00}));
        wr(addr_irq_flags, 8'h00);
        $display("conversion with clock code %0d done", code);
    endtask
    task automatic t_abort();
        logic [7:0] h;
        logic [7:0] l;
        logic [7:0] q;
        int         m;
        rd(addr_result_high, h);
        rd(addr_result_low, l);
        wr(addr_analog_sel, 8'h6f);
        wr(addr_control, 8'h09);
        repeat (20) @(posedge clock_i);
        wr(addr_control, 8'h0b);
        repeat (100) @(posedge clock_i);
        wr(addr_control, 8'h09);
        m = 0;
        while (sample_o !== 1'b1 && m < 300) begin
            @(posedge clock_i);
            m++;
        end
        chk("abort recovery", 16'(m >= 2 * 64 - 8 && m <= 2 * 64 + 4), 16'h0001);
        if (m == 300) end_sim();
        rd(addr_result_high, q);
        chk("kept high", 16'(q), 16'(h));
        rd(addr_result_low, q);
        chk("kept low", 16'(q), 16'(l));
        rd(addr_irq_flags, q);
        chk("no done flag", 16'(q), 16'h0000);
        $display("abort test done");
    endtask
    task automatic t_sleep();
        logic [7:0] q;
        int         m;
        wr(addr_control, 8'h0b);
        repeat (30) @(posedge clock_i);
        sleep_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        rd(addr_control, q);
        chk("sleep abort", 16'(q), 16'h0009);
        chk("sleep off", 16'(converter_active_o), 16'h0000);
        sleep_i <= 1'b0;
        wr(addr_analog_sel, 8'h3f);
        repeat (20) @(posedge clock_i);
        wr(addr_control, 8'h0b);
        sleep_i <= 1'b1;
        m = 0;
        while (wake_o !== 1'b1 && m < 6000) begin
            @(posedge clock_i);
            m++;
        end
        chk("wake", 16'(wake_o), 16'h0001);
        if (m == 6000) end_sim();
        sleep_i <= 1'b0;
        rd(addr_control, q);
        chk("sleep done go", 16'(q), 16'h0009);
        wr(addr_irq_flags, 8'h00);
        $display("sleep test done");
    endtask
    task automatic t_reset();
        logic [7:0] h;
        logic [7:0] q;
        rd(addr_result_high, h);
        wr(addr_analog_sel, 8'h6f);
        wr(addr_control, 8'h0b);
        repeat (30) @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        rd(addr_control, q);
        chk("control after reset", 16'(q), 16'h0000);
        rd(addr_result_high, q);
        chk("result kept", 16'(q), 16'(h));
        $display("reset test done");
    endtask
    // main sequence
    initial begin
        num_errors = 0;
        cmp_count = 0;
        req = '0;
        sleep_i = 1'b0;
        resetn_i = 1'b0;
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_regs();
        wr(addr_irq_enables, 8'h40);
        for (int i = 0; i < 8; i++) begin
            t_convert(codes[i], i < 6 ? 2 << i : 2 * int'(rc_half_cycles), i < 6 ? 2 : 410,
                      {i[0], i[1], 2'b00, i[1:0], 2'b01});
        end
        t_abort();
        t_sleep();
        t_reset();
        end_sim();
    end
endmodule
`default_nettype wire
